// ===== vlcb_pkg.sv
// Constants shared by the line counter and luma/chroma adjust block.
package vlcb_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] VLCB_OFS_CTRL  = 8'h00;
    localparam logic [7:0] VLCB_OFS_ADJ   = 8'h04;
    localparam logic [7:0] VLCB_OFS_STAT  = 8'h08;
    localparam logic [7:0] VLCB_OFS_COUNT = 8'h0C;
    // Control fields.
    localparam int VLCB_CTRL_SYNC_LSB = 0;
    localparam int VLCB_CTRL_WIDE_BIT = 4;
    localparam logic [2:0] VLCB_SYNC_RST  = 3'h0;
    localparam logic       VLCB_WIDE_RST  = 1'b0;
    // Adjust fields.
    localparam int VLCB_ADJ_OFS_LSB  = 0;
    localparam int VLCB_ADJ_GAIN_LSB = 8;
    localparam int VLCB_ADJ_SAT_LSB  = 16;
    localparam logic [7:0] VLCB_OFS_LEVEL_RST = 8'h80;
    localparam logic [6:0] VLCB_GAIN_RST      = 7'h40;
    localparam logic [6:0] VLCB_SAT_RST       = 7'h40;
    // Status and line count fields.
    localparam int VLCB_STAT_EVEN_BIT = 16;
    localparam int VLCB_STAT_ACQ_BIT  = 17;
    localparam int VLCB_STAT_LOCK_BIT = 18;
    localparam int VLCB_COUNT_EVEN_LSB = 16;
    // ************************************************************
    // Sync selection and video constants
    // ************************************************************
    localparam logic [2:0] VLCB_SYNC_FIELD = 3'h6;
    localparam logic [2:0] VLCB_SYNC_CODE  = 3'h7;
    localparam logic [7:0] VLCB_TRS_FF     = 8'hFF;
    localparam logic [7:0] VLCB_TRS_00     = 8'h00;
    localparam logic [8:0] VLCB_MID        = 9'h080;
    localparam logic [11:0] VLCB_LINE_FIRST = 12'h001;
    localparam int VLCB_GAIN_SHIFT = 6;
    // Acquisition states.
    typedef enum logic [2:0] {
        VLCB_IDLE   = 3'b001,
        VLCB_WAIT   = 3'b010,
        VLCB_ACTIVE = 3'b100
    } vlcb_acq_t;
endpackage

// ===== vlcb_top.sv
// Source line counter with selectable sync reset and luma/chroma adjust stage.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module vlcb_top
    import vlcb_pkg::*;
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Video source port.
    input  wire logic [15:0] vid_data,
    input  wire logic        pixel_qualifier,
    input  wire logic        horizontal_sync_input,
    input  wire logic        vertical_sync_input,
    input  wire logic        frame_field_sync_input,
    input  wire logic        vid_locked,
    // Adjusted stream toward the scaler.
    output logic      [15:0] adj_data,
    output logic             adj_valid,
    output logic             adj_chroma,
    output logic             adj_field_even,
    output logic             adj_line_start
);
    // ************************************************************
    // Register file
    // ************************************************************
    logic [2:0]  sync_sel_q;
    logic        wide_mode_q;
    logic [7:0]  luma_offset_level_q;
    logic [6:0]  luma_gain_level_q;
    logic [6:0]  colour_intensity_gain_q;
    logic [11:0] source_line_counter_q;
    logic [11:0] odd_lines_q;
    logic [11:0] even_lines_q;
    logic        field_even_q;
    vlcb_acq_t   acq_q;
    logic        setup;
    logic        wr_en;
    logic        hit;
    logic [31:0] rd_d;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pready;
    assign hit   = paddr == VLCB_OFS_CTRL || paddr == VLCB_OFS_ADJ ||
                   paddr == VLCB_OFS_STAT || paddr == VLCB_OFS_COUNT;

    // Read mux; unmapped offsets read zero and report an error.
    always_comb begin
        rd_d = 32'h0000_0000;
        case (paddr)
            VLCB_OFS_CTRL: begin
                rd_d[VLCB_CTRL_SYNC_LSB +: 3] = sync_sel_q;
                rd_d[VLCB_CTRL_WIDE_BIT]      = wide_mode_q;
            end
            VLCB_OFS_ADJ: begin
                rd_d[VLCB_ADJ_OFS_LSB +: 8]  = luma_offset_level_q;
                rd_d[VLCB_ADJ_GAIN_LSB +: 7] = luma_gain_level_q;
                rd_d[VLCB_ADJ_SAT_LSB +: 7]  = colour_intensity_gain_q;
            end
            VLCB_OFS_STAT: begin
                rd_d[11:0]               = source_line_counter_q;
                rd_d[VLCB_STAT_EVEN_BIT] = field_even_q;
                rd_d[VLCB_STAT_ACQ_BIT]  = acq_q == VLCB_ACTIVE;
                rd_d[VLCB_STAT_LOCK_BIT] = vid_locked;
            end
            VLCB_OFS_COUNT: begin
                rd_d[11:0]                     = odd_lines_q;
                rd_d[VLCB_COUNT_EVEN_LSB +: 12] = even_lines_q;
            end
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // The answer is registered, so every access phase lasts exactly one cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !hit;
            prdata  <= setup ? rd_d : 32'h0000_0000;
        end
    end

    // Live reload allowed.
    // Writes take effect at once, mid field; the stream picks them up next pixel.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_sel_q              <= VLCB_SYNC_RST;
            wide_mode_q             <= VLCB_WIDE_RST;
            luma_offset_level_q     <= VLCB_OFS_LEVEL_RST;
            luma_gain_level_q       <= VLCB_GAIN_RST;
            colour_intensity_gain_q <= VLCB_SAT_RST;
        end else if (wr_en && paddr == VLCB_OFS_CTRL) begin
            sync_sel_q  <= pwdata[VLCB_CTRL_SYNC_LSB +: 3];
            wide_mode_q <= pwdata[VLCB_CTRL_WIDE_BIT];
        end else if (wr_en && paddr == VLCB_OFS_ADJ) begin
            luma_offset_level_q     <= pwdata[VLCB_ADJ_OFS_LSB +: 8];
            luma_gain_level_q       <= pwdata[VLCB_ADJ_GAIN_LSB +: 7];
            colour_intensity_gain_q <= pwdata[VLCB_ADJ_SAT_LSB +: 7];
        end
    end

    // ************************************************************
    // Sync edge and timing reference detection
    // ************************************************************
    logic       vs_q;
    logic       fs_q;
    logic       hs_q;
    logic [1:0] trs_cnt_q;
    logic       code_v_q;
    logic       trs_word;
    logic       eav_word;
    logic       sav_word;
    logic       vs_rise;
    logic       vs_fall;
    logic       fs_edge;
    logic       code_vrise;
    logic       ref_event;
    logic       line_tick;
    logic       event_even;

    // Embedded codes only appear in the 8-bit stream: FF 00 00 then the flag word.
    assign trs_word   = !wide_mode_q && pixel_qualifier && trs_cnt_q == 2'd3;
    assign eav_word   = trs_word && vid_data[4];
    assign sav_word   = trs_word && !vid_data[4];
    assign vs_rise    = vertical_sync_input && !vs_q;
    assign vs_fall    = !vertical_sync_input && vs_q;
    assign fs_edge    = frame_field_sync_input != fs_q;
    assign code_vrise = eav_word && vid_data[5] && !code_v_q;

    always_comb begin
        case (sync_sel_q)
            VLCB_SYNC_CODE:  ref_event = code_vrise;
            VLCB_SYNC_FIELD: ref_event = fs_edge;
            default:         ref_event = sync_sel_q[0] ? vs_fall : vs_rise;
        endcase
    end

    // Own field detector.
    // In vertical sync modes the field is even when the chosen sync edge is out of phase
    // with the line sync, rising or falling alike; in field mode the field pin level gives it.
    always_comb begin
        case (sync_sel_q)
            VLCB_SYNC_CODE:  event_even = vid_data[6];
            VLCB_SYNC_FIELD: event_even = frame_field_sync_input;
            default:         event_even = !horizontal_sync_input;
        endcase
    end

    assign line_tick = (sync_sel_q == VLCB_SYNC_CODE) ? eav_word
                     : (horizontal_sync_input && !hs_q);

    // Delayed copies of the sync pins and the code parser.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vs_q      <= 1'b0;
            fs_q      <= 1'b0;
            hs_q      <= 1'b0;
            trs_cnt_q <= 2'd0;
            code_v_q  <= 1'b0;
        end else begin
            vs_q <= vertical_sync_input;
            fs_q <= frame_field_sync_input;
            hs_q <= horizontal_sync_input;
            if (pixel_qualifier) begin
                if (vid_data[7:0] == VLCB_TRS_FF) begin
                    trs_cnt_q <= 2'd1;
                end else if (vid_data[7:0] == VLCB_TRS_00 && trs_cnt_q != 2'd0
                             && trs_cnt_q != 2'd3) begin
                    trs_cnt_q <= trs_cnt_q + 2'd1;
                end else begin
                    trs_cnt_q <= 2'd0;
                end
            end
            if (eav_word) begin
                code_v_q <= vid_data[5];
            end
        end
    end

    // ************************************************************
    // Source line counter
    // ************************************************************
    // Counter clear.
    // The reset event wins over a line tick in the same cycle, so line one is
    // the line in which the event falls. The offsets per mode follow from this.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_line_counter_q <= 12'h000;
            field_even_q          <= 1'b0;
        end else if (ref_event) begin
            source_line_counter_q <= VLCB_LINE_FIRST;
            field_even_q          <= event_even;
        end else if (line_tick) begin
            source_line_counter_q <= source_line_counter_q + 12'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            odd_lines_q  <= 12'h000;
            even_lines_q <= 12'h000;
        end else if (ref_event && field_even_q) begin
            even_lines_q <= source_line_counter_q;
        end else if (ref_event) begin
            odd_lines_q <= source_line_counter_q;
        end
    end

    // ************************************************************
    // Acquisition control
    // ************************************************************
    // Wait for next field.
    // Losing lock drops to idle; after relock only a fresh field start resumes,
    // so a torn field is never passed on.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acq_q <= VLCB_IDLE;
        end else begin
            case (acq_q)
                VLCB_IDLE:   acq_q <= vid_locked ? VLCB_WAIT : VLCB_IDLE;
                VLCB_WAIT:   acq_q <= !vid_locked ? VLCB_IDLE
                                    : ref_event ? VLCB_ACTIVE : VLCB_WAIT;
                VLCB_ACTIVE: acq_q <= vid_locked ? VLCB_ACTIVE : VLCB_IDLE;
                default:     acq_q <= VLCB_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Luma and chroma adjust
    // ************************************************************
    logic       phase_q;
    logic       is_chroma;
    logic       code_word;
    logic [7:0] y_in;
    logic [7:0] c_in;
    logic [7:0] y_out;
    logic [7:0] c_out;

    function automatic logic [7:0] vlcb_clamp(input logic signed [17:0] v);
        if (v < 18'sd0) begin
            return 8'h00;
        end else if (v > 18'sd255) begin
            return 8'hFF;
        end
        return v[7:0];
    endfunction

    function automatic logic [7:0] vlcb_luma(input logic [7:0] y, input logic [6:0] g,
                                             input logic [7:0] o);
        logic signed [17:0] p;
        p = $signed({3'b000, 15'(({7'h00, y} * {8'h00, g}) >> VLCB_GAIN_SHIFT)})
          + $signed({10'h000, o}) - $signed({9'h000, VLCB_MID});
        return vlcb_clamp(p);
    endfunction

    function automatic logic [7:0] vlcb_chroma(input logic [7:0] c, input logic [6:0] s);
        logic signed [17:0] d;
        d = ($signed({10'h000, c}) - $signed({9'h000, VLCB_MID}))
          * $signed({11'h000, s});
        d = d >>> VLCB_GAIN_SHIFT;
        return vlcb_clamp(d + $signed({9'h000, VLCB_MID}));
    endfunction

    // Word format select.
    // 8-bit words alternate chroma and luma from each start of line; 16-bit
    // words carry luma low and chroma high.
    assign is_chroma = !wide_mode_q && !phase_q;
    // Code words of the 8-bit stream: the leading FF, the zeros after it and the flag word.
    assign code_word = !wide_mode_q && (vid_data[7:0] == VLCB_TRS_FF || trs_word
                       || (vid_data[7:0] == VLCB_TRS_00 && trs_cnt_q != 2'd0));
    assign y_in      = vid_data[7:0];
    assign c_in      = wide_mode_q ? vid_data[15:8] : vid_data[7:0];
    assign y_out     = vlcb_luma(y_in, luma_gain_level_q, luma_offset_level_q);
    assign c_out     = vlcb_chroma(c_in, colour_intensity_gain_q);

    // Byte phase restarts after each start code or line sync.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 1'b0;
        end else if (sav_word || (horizontal_sync_input && !hs_q)) begin
            phase_q <= 1'b0;
        end else if (pixel_qualifier && !code_word) begin
            phase_q <= !phase_q;
        end
    end

    // Qualified pixels adjusted.
    // Code words are not pixels and are never forwarded.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adj_data       <= 16'h0000;
            adj_valid      <= 1'b0;
            adj_chroma     <= 1'b0;
            adj_field_even <= 1'b0;
            adj_line_start <= 1'b0;
        end else begin
            // The lock pin gates at once, since the state only drops a cycle later.
            adj_valid      <= acq_q == VLCB_ACTIVE && vid_locked && pixel_qualifier
                              && !code_word;
            adj_chroma     <= is_chroma;
            adj_data       <= wide_mode_q ? {c_out, y_out}
                              : {8'h00, is_chroma ? c_out : y_out};
            adj_field_even <= field_even_q;
            adj_line_start <= line_tick && acq_q == VLCB_ACTIVE;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_counter_clear: assert property (ref_event |=> source_line_counter_q == 12'h001)
        else $error("line counter not cleared on reset event");
    chk_code_mode: assert property (sync_sel_q == 3'h7 && code_vrise |=>
        source_line_counter_q == 12'h001 && field_even_q == $past(vid_data[6]))
        else $error("embedded code did not reset counter");
    chk_field_mode: assert property (sync_sel_q == 3'h6 && fs_edge |=>
        source_line_counter_q == 12'h001 && field_even_q == $past(frame_field_sync_input))
        else $error("field signal did not reset counter");
    chk_fall_edge: assert property (sync_sel_q == 3'h3 && $fell(vertical_sync_input)
        |=> source_line_counter_q == 12'h001) else $error("falling edge missed");
    chk_rise_edge: assert property (sync_sel_q == 3'h2 && !vs_fall && vs_rise
        |=> source_line_counter_q == 12'h001) else $error("rising edge missed");
    chk_line_count: assert property (!ref_event && line_tick |=>
        source_line_counter_q == $past(source_line_counter_q) + 12'h001)
        else $error("line count did not advance");
    chk_even_count: assert property (ref_event && field_even_q |=>
        even_lines_q == $past(source_line_counter_q) && $stable(odd_lines_q))
        else $error("even field count misfiled");
    chk_idle_unlock: assert property (!vid_locked |=> !adj_valid ##1 !adj_valid)
        else $error("output while unlocked");
    chk_unity_gain: assert property (wide_mode_q && luma_gain_level_q == 7'h40 &&
        luma_offset_level_q == 8'h80 && acq_q == VLCB_ACTIVE && pixel_qualifier
        |=> adj_data[7:0] == $past(vid_data[7:0])) else $error("unity luma altered");
    chk_colour_off: assert property (wide_mode_q && colour_intensity_gain_q == 7'h00
        |=> adj_data[15:8] == 8'h80) else $error("chroma not removed");
    chk_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("bus answer not one cycle");

    cov_code_reset:  cover property (sync_sel_q == 3'h7 ##0 ref_event);
    cov_acq_start:   cover property (acq_q == VLCB_WAIT ##1 acq_q == VLCB_ACTIVE);
    cov_clamp_high:  cover property (adj_valid && adj_data[7:0] == 8'hFF);
    cov_even_field:  cover property (ref_event && event_even);
endmodule // vlcb_top

// ===== vlcb_src_model.sv
// Behavioural video source driving the capture block's input pins.
`timescale 1ns/1ns
module vlcb_src_model (
    // Clock.
    input  wire logic        pclk,
    // Source pins.
    output logic      [15:0] vid_data,
    output logic             pixel_qualifier,
    output logic             horizontal_sync_input,
    output logic             vertical_sync_input,
    output logic             frame_field_sync_input,
    output logic             vid_locked
);
    // All pins idle low until the bench asks for traffic.
    initial begin
        vid_data               = 16'h0000;
        pixel_qualifier        = 1'b0;
        horizontal_sync_input  = 1'b0;
        vertical_sync_input    = 1'b0;
        frame_field_sync_input = 1'b0;
        vid_locked             = 1'b0;
    end
    task automatic word(input logic [15:0] d);
        @(posedge pclk);
        vid_data        <= d;
        pixel_qualifier <= 1'b1;
        @(posedge pclk);
        pixel_qualifier <= 1'b0;
        // Released data is inverted so a stale word can never look fresh.
        vid_data        <= ~d;
    endtask
    // Embedded reference code sent as four 8-bit words.
    task automatic code(input logic [7:0] xy);
        word(16'h00FF);
        word(16'h0000);
        word(16'h0000);
        word({8'h00, xy});
    endtask
    // One rising edge on the line sync pin.
    task automatic line();
        @(posedge pclk);
        horizontal_sync_input <= 1'b1;
        @(posedge pclk);
        horizontal_sync_input <= 1'b0;
    endtask
    task automatic pins(input logic vs, input logic fld, input logic lk);
        @(posedge pclk);
        vertical_sync_input    <= vs;
        frame_field_sync_input <= fld;
        vid_locked             <= lk;
    endtask
endmodule // vlcb_src_model

// ===== vlcb_top_tb.sv
// Self-checking bench for the line counter and luma/chroma adjust block.
`timescale 1ns/1ns
module vlcb_top_tb import vlcb_pkg::*;;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] vd;
    logic [15:0] adj_data;
    logic        pq, hs, vs, fld, lk, adj_valid;
    logic        adj_chroma, adj_field_even, adj_line_start;
    logic [31:0] rd;
    logic        err;
    int          num_errors   = 0;
    int          total_checks = 0;
    // Clock of 100 ns period.
    always #50 pclk = ~pclk;
    vlcb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vid_data(vd), .pixel_qualifier(pq), .horizontal_sync_input(hs),
        .vertical_sync_input(vs), .frame_field_sync_input(fld), .vid_locked(lk),
        .adj_data(adj_data), .adj_valid(adj_valid), .adj_chroma(adj_chroma),
        .adj_field_even(adj_field_even), .adj_line_start(adj_line_start));
    vlcb_src_model src (.pclk(pclk), .vid_data(vd), .pixel_qualifier(pq),
        .horizontal_sync_input(hs), .vertical_sync_input(vs),
        .frame_field_sync_input(fld), .vid_locked(lk));
    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One APB transfer; the wait for pready is bounded.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            report_and_stop();
        end
    endtask
    // Saturating conversion to a pixel value.
    function automatic logic [7:0] clamp(input int v);
        return v < 0 ? 8'h00 : (v > 255 ? 8'hFF : 8'(v));
    endfunction
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        int         sel, n, i;
        logic [7:0] o, y, c;
        logic [6:0] g, s;
        logic [7:0] ot[3] = '{8'h00, 8'hFF, 8'h80};
        logic [6:0] gt[3] = '{7'h00, 7'h7F, 7'h40};
        void'($urandom(32'h38f5));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, VLCB_OFS_ADJ, 32'h0000_0000);
        check("adj reset", rd, 32'h0040_4080);
        apb(1'b1, 8'h10, 32'h0000_0000);
        check("unmapped err", 32'(err), 32'h0000_0001);
        // Each pin sync setting (0 to 6) clears the count; then n line ticks follow.
        for (sel = 0; sel < 7; sel++) begin
            n = $urandom_range(1, 5);
            src.pins(sel[0], 1'b0, 1'b1);
            apb(1'b1, VLCB_OFS_CTRL, 32'(sel) | 32'h0000_0010);
            src.pins(sel == 6 ? sel[0] : ~sel[0], sel == 6, 1'b1);
            repeat (n) src.line();
            repeat (2) @(posedge pclk);
            apb(1'b0, VLCB_OFS_STAT, 32'h0000_0000);
            check("line count", {20'h0_0000, rd[11:0]}, 32'(n + 1));
            check("field even", 32'(rd[16]), 32'h0000_0001);
        end
        // Leaving the even field files its length apart from odd fields.
        src.pins(1'b0, 1'b0, 1'b1);
        repeat (2) @(posedge pclk);
        apb(1'b0, VLCB_OFS_COUNT, 32'h0000_0000);
        check("even length", {20'h0_0000, rd[27:16]}, 32'(n + 1));
        // Embedded codes: blanking start clears, later codes tick.
        apb(1'b1, VLCB_OFS_CTRL, 32'h0000_0007);
        src.code(8'h90);
        src.code(8'hF0);
        repeat (3) src.code(8'hF0);
        apb(1'b0, VLCB_OFS_STAT, 32'h0000_0000);
        check("code count", {20'h0_0000, rd[11:0]}, 32'h0000_0004);
        check("code field", 32'(rd[16]), 32'h0000_0001);
        // 8-bit words: code words are dropped, then chroma and luma alternate.
        src.word(16'h00FF);
        src.word(16'h0000);
        #1;
        check("code word drop", 32'(adj_valid), 32'h0000_0000);
        src.word(16'h0000);
        src.word(16'h0080);
        src.word(16'h0033);
        #1;
        check("narrow chroma", {14'h0000, adj_valid, adj_chroma, adj_data}, 32'h0003_0033);
        src.word(16'h0044);
        #1;
        check("narrow luma", {14'h0000, adj_valid, adj_chroma, adj_data}, 32'h0002_0044);
        check("field flag out", 32'(adj_field_even), 32'h0000_0001);
        src.code(8'hF0);
        #1;
        check("line start", {30'h0000_0000, adj_line_start, adj_valid}, 32'h0000_0002);
        // Adjust stage in 16-bit mode, reloading settings mid-stream.
        apb(1'b1, VLCB_OFS_CTRL, 32'h0000_0010);
        src.pins(1'b1, 1'b0, 1'b1);
        for (i = 0; i < 24; i++) begin
            o = i < 3 ? ot[i] : 8'($urandom);
            g = i < 3 ? gt[i] : 7'($urandom);
            s = i < 3 ? gt[i] : 7'($urandom);
            y = i == 1 ? 8'hFF : 8'($urandom);
            c = i == 0 ? 8'h00 : (i == 1 ? 8'hFF : 8'($urandom));
            apb(1'b1, VLCB_OFS_ADJ, {9'h000, s, 1'b0, g, o});
            src.word({c, y});
            #1;
            check("adj valid", 32'(adj_valid), 32'h0000_0001);
            check("adj data", {16'h0000, adj_data}, {16'h0000,
                clamp(((int'(c) - 128) * int'(s) >>> 6) + 128),
                clamp((int'(y) * int'(g) >>> 6) + int'(o) - 128)});
        end
        // No output without lock, nor after relock until a sync event.
        src.pins(1'b1, 1'b0, 1'b0);
        src.word(16'h8080);
        #1;
        check("valid unlocked", 32'(adj_valid), 32'h0000_0000);
        apb(1'b0, VLCB_OFS_STAT, 32'h0000_0000);
        check("lock bit", 32'(rd[18]), 32'h0000_0000);
        src.pins(1'b1, 1'b0, 1'b1);
        src.word(16'h8080);
        #1;
        check("valid relock", 32'(adj_valid), 32'h0000_0000);
        src.pins(1'b0, 1'b0, 1'b1);
        src.pins(1'b1, 1'b0, 1'b1);
        src.word(16'h8080);
        #1;
        check("valid resumed", 32'(adj_valid), 32'h0000_0001);
        report_and_stop();
    end
endmodule // vlcb_top_tb
